// File: rtl/cskip_cfg.svh
`ifndef CSKIP_CFG_SVH
`define CSKIP_CFG_SVH
// Opcode fields of the compare-and-skip group (upper five bits).
`define CSKIP_OP_HI        5'h0c
`define CSKIP_OP_HI_LSB    11
`define CSKIP_SEL_LSB      9
`define CSKIP_SEL_EQ       2'h1
`define CSKIP_SEL_GT       2'h2
`define CSKIP_SEL_LT       2'h0
`define CSKIP_ACCESS_BIT   8
// Literal offset limit for indexed addressing.
`define CSKIP_LIT_MAX      8'h5f
// Access bank split: low operands map to bank 0, high ones to bank 15.
`define CSKIP_ACC_SPLIT    8'h60
`define CSKIP_ACC_HI_BANK  4'hf
`define CSKIP_ACC_LO_BANK  4'h0
`define CSKIP_Q_LAST       2'h3
`endif

// File: rtl/cskip_pkg.sv
package cskip_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic        indexed;
      logic [7:0]  offset;
   } cskip_addr_s;
   typedef enum logic [1:0] {
      CSKIP_CMP_LT,
      CSKIP_CMP_EQ,
      CSKIP_CMP_GT,
      CSKIP_CMP_NONE
   } cskip_cmp_e;
endpackage

// File: rtl/cskip_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "cskip_cfg.svh"
module cskip_addr_gen (
   input  wire logic [7:0]  fileOp,       // File operand field
   input  wire logic        accessSel,    // Access bit of the instruction
   input  wire logic [3:0]  bankSel,      // Bank select register value
   input  wire logic        extEnable,    // Extended instruction set on
   output var cskip_pkg::cskip_addr_s addrOut // Resolved data address
);
   wire isLiteral;
   wire accessHigh;
   wire [3:0] accessBank;
   wire [11:0] bankAddr;
   wire [11:0] accessAddr;

   assign isLiteral = extEnable && !accessSel && (fileOp <= `CSKIP_LIT_MAX);
   assign accessHigh = fileOp >= `CSKIP_ACC_SPLIT;
   assign accessBank = accessHigh ? `CSKIP_ACC_HI_BANK : `CSKIP_ACC_LO_BANK;
   assign accessAddr = {accessBank, fileOp};
   assign bankAddr = {bankSel, fileOp};
   assign addrOut = '{addr:    accessSel ? bankAddr : accessAddr,
                      indexed: isLiteral,
                      offset:  fileOp};
endmodule
`default_nettype wire

// File: rtl/cskip_unit.sv
// Summary of operation
// - Equal compare by subtraction, flags untouched.
// - Equal discards next word, runs no-operation.
// - Skipped two-word instruction costs third cycle.
// - Access bit zero uses fixed access bank.
// - Access bit one uses bank select register.
// - Extended mode, access bit zero, operand up to 95 is literal.
`timescale 1ns/1ps
`default_nettype none
`include "cskip_cfg.svh"
module cskip_unit (
   input  wire logic        clk_sys,     // Core clock
   input  wire logic        srst,        // Synchronous reset, active high
   input  wire logic [1:0]  qPhase,      // Current instruction phase
   input  wire logic        instValid,   // Instruction word present at phase 0
   input  wire logic [15:0] instWord,    // Current instruction word
   input  wire logic        nextTwoWord, // Fetched next instruction is 2 words
   input  wire logic [7:0]  workReg,     // Working register value
   input  wire logic [7:0]  fileData,    // Data read from the resolved address
   input  wire logic [3:0]  bankSel,     // Bank select register value
   input  wire logic        extEnable,   // Extended instruction set enabled
   output logic [11:0]      dataAddr,    // Resolved data address
   output logic             indexedMode, // Operand is a literal offset
   output logic             isCompare,   // Compare-and-skip in execution
   output logic             skipFlush,   // Discard fetched instruction
   output logic             nopCycle,    // Executing a no-operation cycle
   output logic             flagWrite    // Arithmetic flag write strobe
);
   typedef enum logic [1:0] {ST_RUN, ST_NOP1, ST_NOP2} cskip_st_e;
   cskip_st_e state_ff;
   cskip_st_e nxt_state;

   cskip_pkg::cskip_addr_s addrNow;
   cskip_pkg::cskip_cmp_e  cmpKind;
   wire opMatch;
   wire lastQ;
   wire [8:0] diff;
   wire isEqual;
   wire isGreater;
   wire isLess;
   wire skipTake;
   logic [11:0] dataAddr_ff;
   logic indexed_ff;
   logic isCmp_ff;
   logic cmpAct_ff;
   cskip_pkg::cskip_cmp_e cmpKind_ff;
   logic skip_ff;
   logic nop_ff;
   logic twoWord_ff;
   logic flag_ff;
   wire [1:0] selField;
   wire groupHit;
   wire selEq;
   wire selGt;
   wire selLt;
   wire nxt_cmpAct;
   cskip_pkg::cskip_cmp_e nxt_cmpKind;
   wire nxt_twoWord;
   wire [11:0] nxt_dataAddr;
   wire nxt_indexed;
   wire nxt_isCmp;
   wire nxt_nop;

   cskip_addr_gen u_addr (
      .fileOp    (instWord[7:0]),
      .accessSel (instWord[`CSKIP_ACCESS_BIT]),
      .bankSel   (bankSel),
      .extEnable (extEnable),
      .addrOut   (addrNow)
   );

   assign selField = instWord[`CSKIP_SEL_LSB +: 2];
   assign groupHit = instWord[15:`CSKIP_OP_HI_LSB] == `CSKIP_OP_HI;
   assign selEq    = selField == `CSKIP_SEL_EQ;
   assign selGt    = selField == `CSKIP_SEL_GT;
   assign selLt    = selField == `CSKIP_SEL_LT;
   // The fourth select code is another instruction; it must neither
   // latch an address nor start a compare.
   assign opMatch = instValid && (state_ff == ST_RUN) && groupHit &&
                    (selEq || selGt || selLt);
   assign cmpKind = !opMatch ? cskip_pkg::CSKIP_CMP_NONE :
                    selEq    ? cskip_pkg::CSKIP_CMP_EQ :
                    selGt    ? cskip_pkg::CSKIP_CMP_GT :
                    selLt    ? cskip_pkg::CSKIP_CMP_LT :
                    cskip_pkg::CSKIP_CMP_NONE;
   assign lastQ = qPhase == `CSKIP_Q_LAST;
   assign diff = {1'b0, fileData} - {1'b0, workReg};
   assign isEqual = diff == 9'h000;
   assign isGreater = !diff[8] && !isEqual;
   assign isLess = diff[8];
   assign skipTake = cmpAct_ff && lastQ &&
                     ((cmpKind_ff == cskip_pkg::CSKIP_CMP_EQ && isEqual) ||
                      (cmpKind_ff == cskip_pkg::CSKIP_CMP_GT && isGreater) ||
                      (cmpKind_ff == cskip_pkg::CSKIP_CMP_LT && isLess));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (skipTake) begin
               nxt_state = ST_NOP1;
            end
         end
         ST_NOP1: begin
            if (lastQ) begin
               nxt_state = twoWord_ff ? ST_NOP2 : ST_RUN;
            end
         end
         ST_NOP2: begin
            if (lastQ) begin
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // The compare stays armed from decode through the last phase, so the
   // data read may settle as late as the final phase edge.
   assign nxt_cmpAct   = opMatch || (cmpAct_ff && !lastQ);
   assign nxt_cmpKind  = opMatch ? cmpKind : cmpKind_ff;
   assign nxt_dataAddr = opMatch ? addrNow.addr : dataAddr_ff;
   assign nxt_indexed  = opMatch ? addrNow.indexed : indexed_ff;
   assign nxt_isCmp    = cmpAct_ff || opMatch;
   // size of skipped word
   // The size is caught at the skip edge because the fetch side may move
   // on while the no-operation cycles run.
   assign nxt_twoWord  = skipTake ? nextTwoWord : twoWord_ff;
   assign nxt_nop      = nxt_state != ST_RUN;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmpAct_ff <= 1'b0;
      end else begin
         cmpAct_ff <= nxt_cmpAct;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmpKind_ff <= cskip_pkg::CSKIP_CMP_NONE;
      end else begin
         cmpKind_ff <= nxt_cmpKind;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         twoWord_ff <= 1'b0;
      end else begin
         twoWord_ff <= nxt_twoWord;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dataAddr_ff <= 12'h000;
      end else begin
         dataAddr_ff <= nxt_dataAddr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         indexed_ff <= 1'b0;
      end else begin
         indexed_ff <= nxt_indexed;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         isCmp_ff <= 1'b0;
      end else begin
         isCmp_ff <= nxt_isCmp;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         skip_ff <= 1'b0;
      end else begin
         skip_ff <= skipTake;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         nop_ff <= 1'b0;
      end else begin
         nop_ff <= nxt_nop;
      end
   end

   // flags never written
   // A compare only reads; the strobe still leaves a register so that
   // its timing matches every other output.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= 1'b0;
      end
   end

   assign dataAddr    = dataAddr_ff;
   assign indexedMode = indexed_ff;
   assign isCompare   = isCmp_ff;
   assign skipFlush   = skip_ff;
   assign nopCycle    = nop_ff;
   assign flagWrite   = flag_ff;
endmodule
`default_nettype wire

// File: verif/cskip_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cskip_unit_assertions (
   input wire logic        clk_sys,     // Core clock
   input wire logic        srst,        // Synchronous reset
   input wire logic [1:0]  qPhase,      // Instruction phase
   input wire logic [15:0] instWord,    // Instruction word
   input wire logic        nextTwoWord, // Next instruction is two words
   input wire logic [7:0]  workReg,     // Working register
   input wire logic [7:0]  fileData,    // Data read
   input wire logic [3:0]  bankSel,     // Bank select
   input wire logic        extEnable,   // Extended set on
   input wire logic [11:0] dataAddr,    // Resolved address
   input wire logic        indexedMode, // Literal offset flag
   input wire logic        isCompare,   // Compare executing
   input wire logic        skipFlush,   // Discard strobe
   input wire logic        nopCycle,    // No-operation cycle
   input wire logic        flagWrite    // Flag write strobe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire logic       dec     = isCompare && qPhase == 2'h3;
   wire logic       eqNow   = fileData == workReg;
   wire logic       gtNow   = fileData > workReg;
   wire logic [1:0] sel     = instWord[10:9];
   wire logic [3:0] accBank = instWord[7:0] < 8'h60 ? 4'h0 : 4'hf;
   a_flag_quiet: assert property (!flagWrite)
      else $error("flag strobe seen");
   a_eq_skip: assert property (dec && sel == 2'h1
      |=> skipFlush == $past(eqNow))
      else $error("equal skip wrong");
   a_gt_skip: assert property (dec && sel == 2'h2
      |=> skipFlush == $past(gtNow))
      else $error("greater skip wrong");
   a_nop_one: assert property (skipFlush && !$past(nextTwoWord)
      |-> nopCycle [*4] ##1 !nopCycle)
      else $error("one nop cycle wrong");
   a_nop_two: assert property (skipFlush && $past(nextTwoWord)
      |-> nopCycle [*8] ##1 !nopCycle)
      else $error("two nop cycles wrong");
   a_bank_addr: assert property ($rose(isCompare) && instWord[8]
      |-> dataAddr == {bankSel, instWord[7:0]})
      else $error("banked address wrong");
   a_access_bank: assert property ($rose(isCompare) && !instWord[8]
      |-> dataAddr == {accBank, instWord[7:0]})
      else $error("access bank address wrong");
   a_index_mode: assert property ($rose(isCompare) |-> indexedMode ==
      (extEnable && !instWord[8] && instWord[7:0] <= 8'h5f))
      else $error("indexed flag wrong");
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_sys     = 1'b0;
   logic        srst        = 1'b1;
   logic        instValid   = 1'b0;
   logic        nextTwoWord = 1'b0;
   logic        extEnable   = 1'b0;
   logic [1:0]  qPhase      = 2'h0;
   logic [15:0] instWord    = 16'h0000;
   logic [7:0]  workReg     = 8'h00;
   logic [7:0]  fileData    = 8'h00;
   logic [7:0]  w;
   logic [3:0]  bankSel     = 4'h0;
   logic [11:0] dataAddr;
   logic        indexedMode;
   logic        isCompare;
   logic        skipFlush;
   logic        nopCycle;
   logic        flagWrite;
   logic        e;
   int          bad_count   = 0;
   int          n_checks    = 0;
   int          nops;
   int          cmps;
   cskip_unit i_dut (.clk_sys(clk_sys), .srst(srst), .qPhase(qPhase),
      .instValid(instValid), .instWord(instWord), .nextTwoWord(nextTwoWord),
      .workReg(workReg), .fileData(fileData), .bankSel(bankSel),
      .extEnable(extEnable), .dataAddr(dataAddr), .indexedMode(indexedMode),
      .isCompare(isCompare), .skipFlush(skipFlush), .nopCycle(nopCycle),
      .flagWrite(flagWrite));
   initial forever #20 clk_sys = ~clk_sys;
   task check(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function logic hit(input logic [1:0] s, input logic [7:0] d,
                      input logic [7:0] r);
      return s == 2'h1 ? d == r : s == 2'h2 ? d > r : d < r;
   endfunction
   function logic [11:0] exp_addr(input logic a, input logic [7:0] f);
      return a ? {bankSel, f} : {f < 8'h60 ? 4'h0 : 4'hf, f};
   endfunction
   task run(input logic [1:0] s, input logic [7:0] f, input logic a,
            input logic [7:0] d);
      @(negedge clk_sys);
      instWord = {5'h0c, s, a, f};
      instValid = 1'b1;
      fileData = d;
      qPhase = 2'h0;
      e = hit(s, d, workReg);
      for (int i = 1; i < 4; i++) begin
         @(negedge clk_sys);
         instValid = 1'b0;
         qPhase = 2'(i);
      end
      check(isCompare, 1);
      check(indexedMode, extEnable && !a && f <= 8'h5f);
      if (a) begin
         check(dataAddr, exp_addr(a, f));
      end else if (!extEnable || f > 8'h5f) begin
         check(dataAddr, exp_addr(a, f));
      end
      @(negedge clk_sys);
      qPhase = 2'h0;
      check(skipFlush, e);
      // A word offered now must be ignored: mid-skip, or not a compare.
      instValid = 1'b1;
      if (!e) begin
         instWord[10:9] = 2'h3;
      end
      nops = 0;
      cmps = 0;
      repeat (11) begin
         nops += (nopCycle === 1'b1);
         cmps += (isCompare === 1'b1);
         check(flagWrite, 0);
         @(negedge clk_sys);
         instValid = 1'b0;
         qPhase = qPhase + 2'h1;
      end
      check(12'(nops), e ? (nextTwoWord ? 8 : 4) : 0);
      check(12'(cmps), 1);
   endtask
   initial begin
      void'($urandom(32'h9725de69));
      repeat (12) @(negedge clk_sys);
      srst = 0;
      for (int k = 0; k < 48; k++) begin
         nextTwoWord = k[0];
         extEnable = k[1];
         bankSel = 4'($urandom);
         w = 8'($urandom);
         workReg = w;
         run(2'(k % 3), k < 8 ? 8'h5c + 8'(k) : 8'($urandom),
             k < 8 ? k[2] : 1'($urandom), k % 4 == 0 ? w : 8'($urandom));
      end
      stop_test;
   end
   initial begin
      #100000;
      bad_count++;
      stop_test;
   end
endmodule
bind cskip_unit cskip_unit_assertions i_chk (.clk_sys(clk_sys), .srst(srst),
   .qPhase(qPhase), .instWord(instWord), .nextTwoWord(nextTwoWord),
   .workReg(workReg), .fileData(fileData), .bankSel(bankSel),
   .extEnable(extEnable), .dataAddr(dataAddr), .indexedMode(indexedMode),
   .isCompare(isCompare), .skipFlush(skipFlush), .nopCycle(nopCycle),
   .flagWrite(flagWrite));
`default_nettype wire
